// [core/rip_regs.sv]
// reset, identification and power-management register bank on wishbone
// Contract
// - write to index zero restores all defaults
// - index zero reads the fixed part identifier
// - index 0x100 reads customer code and revision
// - after reset pins input, record outputs driven
// - software reset gives power-on pin states
// - shared mic pin starts as analogue input
// - writes ignored during power-on reset
`timescale 1ns/1ns
module rip_regs #(
   parameter logic [15:0] PART_ID   = 16'hA5C3,  // arbitrary identifier value
   parameter logic [7:0]  CUST_CODE = 8'h5A,     // arbitrary customer code
   parameter logic [3:0]  SI_REV    = 4'h1       // arbitrary revision
) (
   input  wire logic        clk_i,                // system clock, 100 MHz
   input  wire logic        rst_i,                // synchronous reset, active high
   input  wire logic        cyc_i,                // wishbone cycle
   input  wire logic        stb_i,                // wishbone strobe
   input  wire logic        we_i,                 // wishbone write enable
   input  wire logic [11:0] adr_i,                // wishbone byte address
   input  wire logic [3:0]  sel_i,                // wishbone byte selects
   input  wire logic [31:0] dat_i,                // wishbone write data
   output logic [31:0]      dat_o,                // wishbone read data
   output logic             ack_o,                // wishbone acknowledge
   output logic             err_o,                // unmapped address answer
   output logic [15:0]      pwr_out_o,            // output and bias enables
   output logic [15:0]      pwr_in_o,             // input and thermal enables
   output logic [15:0]      pwr_line_o,           // line and mixer enables
   output logic [15:0]      pwr_rec_o,            // record path enables
   output logic [15:0]      pwr_play_o,           // playback path enables
   output logic [15:0]      src_sel_o,            // serial port source select
   output logic             shared_mic_dig_o,     // shared mic pin digital function
   output logic             dmic_clk_oe_o,        // digital mic clock drive enable
   output logic             rec_out_oe_o,         // record data output drive enable
   output logic             port3_pd_o,           // port three pull-downs
   output logic             port3_oe_o,           // port three drive enable
   output logic             soft_rst_o            // software reset in progress
);
   localparam logic [15:0] MASKS [rip_pkg::NUM_PWR] = '{rip_pkg::MASK_PWR_OUT, rip_pkg::MASK_PWR_IN,
      rip_pkg::MASK_PWR_LINE, rip_pkg::MASK_PWR_REC, rip_pkg::MASK_PWR_PLAY, rip_pkg::MASK_SRC_SEL};
   localparam logic [15:0] RSTV [rip_pkg::NUM_PWR] = '{rip_pkg::RST_PWR_OUT, rip_pkg::RST_PWR_IN,
      rip_pkg::RST_PWR_LINE, rip_pkg::RST_PWR_REC, rip_pkg::RST_PWR_PLAY, rip_pkg::RST_SRC_SEL};

   logic                 por;
   logic                 req;
   logic [9:0]           idx;
   logic                 hit_id;
   logic                 hit_rev;
   logic                 hit_pwr;
   logic                 take;
   logic [1:0]           srst_cnt_reg;
   logic                 regs_rst;
   logic [15:0]          pwr_reg [rip_pkg::NUM_PWR];
   logic [15:0]          rd_next;
   rip_pkg::rip_bus_type bus_reg;

   // internal power-on reset stretcher
   rip_por_gen #(
      .HOLD_CYC (rip_pkg::POR_CYC)
   ) u_por (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .por_o (por)
   );

   // address decode on word index
   assign req     = cyc_i && stb_i && (bus_reg == rip_pkg::BUS_IDLE);
   assign idx     = adr_i[11:2];
   assign hit_id  = (idx == {1'b0, rip_pkg::IDX_RESET_ID});
   assign hit_rev = (idx == {1'b0, rip_pkg::IDX_CUST_REV});
   assign hit_pwr = (idx >= {1'b0, rip_pkg::IDX_PWR_OUT}) && (idx <= {1'b0, rip_pkg::IDX_SRC_SEL});
   // writes are taken only once power-on reset and soft reset are over
   assign take    = req && we_i && !por && !soft_rst_o;

   // one-cycle ack or err per request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_reg <= rip_pkg::BUS_IDLE;
         ack_o   <= 1'b0;
         err_o   <= 1'b0;
      end else begin
         unique case (bus_reg)
            rip_pkg::BUS_IDLE: begin
               ack_o <= req && (hit_id || hit_rev || hit_pwr);
               err_o <= req && !(hit_id || hit_rev || hit_pwr);
               if (req) begin
                  bus_reg <= rip_pkg::BUS_ACK;
               end
            end
            rip_pkg::BUS_ACK: begin
               ack_o   <= 1'b0;
               err_o   <= 1'b0;
               bus_reg <= rip_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   // software reset: any data written to index zero starts a short pulse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         srst_cnt_reg <= 2'h0;
      end else if (take && hit_id && (sel_i[1:0] != 2'h0)) begin
         srst_cnt_reg <= rip_pkg::SOFT_RST_CYC;
      end else if (srst_cnt_reg != 2'h0) begin
         srst_cnt_reg <= srst_cnt_reg - 2'h1;
      end
   end

   assign soft_rst_o = (srst_cnt_reg != 2'h0);
   assign regs_rst   = por || soft_rst_o;

   // power registers, undocumented bits held at zero by mask
   for (genvar g = 0; g < rip_pkg::NUM_PWR; g++) begin : g_pwr
      always_ff @(posedge clk_i) begin
         if (regs_rst) begin
            pwr_reg[g] <= RSTV[g];
         end else if (take && (idx == 10'(g + 1))) begin
            if (sel_i[0]) begin
               pwr_reg[g][7:0] <= dat_i[7:0] & MASKS[g][7:0];
            end
            if (sel_i[1]) begin
               pwr_reg[g][15:8] <= dat_i[15:8] & MASKS[g][15:8];
            end
         end
      end
   end

   assign pwr_out_o  = pwr_reg[0];
   assign pwr_in_o   = pwr_reg[1];
   assign pwr_line_o = pwr_reg[2];
   assign pwr_rec_o  = pwr_reg[3];
   assign pwr_play_o = pwr_reg[4];
   assign src_sel_o  = pwr_reg[5];

   // read multiplexer
   always_comb begin
      rd_next = 16'h0000;
      if (hit_id) begin
         rd_next = PART_ID;
      end else if (hit_rev) begin
         rd_next = 16'h0000;
         rd_next[rip_pkg::CUST_LSB +: 8] = CUST_CODE;
         rd_next[rip_pkg::REV_LSB +: 4]  = SI_REV;
      end else if (hit_pwr) begin
         rd_next = pwr_reg[idx[2:0] - 3'h1];
      end
   end

   // read data registered with the answer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (req && !we_i) begin
         dat_o <= {16'h0000, rd_next};
      end
   end

   // pin state control, reset by power-on or software reset
   rip_pin_ctrl u_pins (
      .clk_i            (clk_i),
      .rst_i            (regs_rst),
      .pwr_rec_i        (pwr_rec_o),
      .src_sel_i        (src_sel_o),
      .shared_mic_dig_o (shared_mic_dig_o),
      .dmic_clk_oe_o    (dmic_clk_oe_o),
      .rec_out_oe_o     (rec_out_oe_o),
      .port3_pd_o       (port3_pd_o),
      .port3_oe_o       (port3_oe_o)
   );

   a_srst_defaults : assert property (@(posedge clk_i) disable iff (rst_i)
      (take && hit_id && sel_i[1:0] != 2'h0) |=> ##1 (pwr_in_o == rip_pkg::RST_PWR_IN && pwr_out_o == 16'h0000))
      else $error("soft reset did not restore defaults");
   a_id_read : assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !we_i && hit_id) |=> (ack_o && dat_o[15:0] == PART_ID))
      else $error("index zero did not read identifier");
   a_rev_read : assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !we_i && hit_rev) |=> (dat_o[15:8] == CUST_CODE && dat_o[3:0] == SI_REV && dat_o[7:4] == 4'h0))
      else $error("revision word wrong");
   a_por_ignore : assert property (@(posedge clk_i) disable iff (rst_i)
      (por && req && we_i) |=> ($stable(pwr_in_o) && !soft_rst_o && pwr_out_o == rip_pkg::RST_PWR_OUT))
      else $error("write taken during power-on reset");
   a_any_data_rst : assert property (@(posedge clk_i) disable iff (rst_i)
      (take && hit_id && sel_i[1:0] != 2'h0) |=> soft_rst_o [*2])
      else $error("write to index zero did not reset");
   a_srst_pins : assert property (@(posedge clk_i) disable iff (rst_i)
      soft_rst_o |=> (!shared_mic_dig_o && port3_pd_o && !port3_oe_o))
      else $error("pins not in reset state after soft reset");
   a_bus_ack_one : assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   a_mic_start : assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(por) |-> !shared_mic_dig_o && rec_out_oe_o)
      else $error("shared mic pin not analogue after power-on");
endmodule : rip_regs

// [core/rip_pkg.sv]
// constants for the reset, identification and power register bank
package rip_pkg;
   localparam int unsigned REG_W          = 16;
   // register indices; byte address is four times the index
   localparam logic [8:0]  IDX_RESET_ID   = 9'h000;
   localparam logic [8:0]  IDX_PWR_OUT    = 9'h001;
   localparam logic [8:0]  IDX_PWR_IN     = 9'h002;
   localparam logic [8:0]  IDX_PWR_LINE   = 9'h003;
   localparam logic [8:0]  IDX_PWR_REC    = 9'h004;
   localparam logic [8:0]  IDX_PWR_PLAY   = 9'h005;
   localparam logic [8:0]  IDX_SRC_SEL    = 9'h006;
   localparam logic [8:0]  IDX_CUST_REV   = 9'h100;
   localparam int unsigned NUM_PWR        = 6;
   // writable masks of the power registers (undocumented bits stay zero)
   localparam logic [15:0] MASK_PWR_OUT   = 16'h3B37;
   localparam logic [15:0] MASK_PWR_IN    = 16'h6BF0;
   localparam logic [15:0] MASK_PWR_LINE  = 16'h3EF0;
   localparam logic [15:0] MASK_PWR_REC   = 16'h330F;
   localparam logic [15:0] MASK_PWR_PLAY  = 16'h3303;
   localparam logic [15:0] MASK_SRC_SEL   = 16'h07BF;
   // values after reset
   localparam logic [15:0] RST_PWR_OUT    = 16'h0000;
   localparam logic [15:0] RST_PWR_IN     = 16'h6000;
   localparam logic [15:0] RST_PWR_LINE   = 16'h0000;
   localparam logic [15:0] RST_PWR_REC    = 16'h0000;
   localparam logic [15:0] RST_PWR_PLAY   = 16'h0000;
   localparam logic [15:0] RST_SRC_SEL    = 16'h0000;
   // field positions in the customer and revision word
   localparam int unsigned CUST_LSB       = 8;
   localparam int unsigned REV_LSB        = 0;
   // field positions used by pin control
   localparam int unsigned DMIC1L_BIT     = 3;
   localparam int unsigned DMIC1R_BIT     = 2;
   localparam int unsigned AIF3_TRI_BIT   = 5;
   // soft reset pulse length in cycles
   localparam logic [1:0]  SOFT_RST_CYC   = 2'h2;
   // internal power-on reset hold, 100 ns minimum
   localparam int unsigned POR_NS         = 100;
   localparam int unsigned CLK_NS         = 10;
   localparam int unsigned POR_CYC        = (POR_NS + CLK_NS - 1) / CLK_NS;
   // wishbone slave phases
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } rip_bus_type;
endpackage : rip_pkg

// [core/rip_por_gen.sv]
// internal power-on reset stretcher
`timescale 1ns/1ns
module rip_por_gen #(
   parameter int unsigned HOLD_CYC = rip_pkg::POR_CYC
) (
   input  wire logic clk_i,       // system clock
   input  wire logic rst_i,       // synchronous reset, active high
   output logic      por_o        // internal reset, active high
);
   logic [7:0] cnt_reg;

   // holds the internal reset for the minimum period after release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= 8'h00;
      end else if (cnt_reg != HOLD_CYC[7:0]) begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   assign por_o = rst_i || (cnt_reg != HOLD_CYC[7:0]);

   a_por_hold_len : assert property (@(posedge clk_i) $fell(rst_i) |-> por_o [*8])
      else $error("power-on reset released too early");
endmodule : rip_por_gen

// [core/rip_pin_ctrl.sv]
// digital pin state generator driven by the power registers
`timescale 1ns/1ns
module rip_pin_ctrl (
   input  wire logic        clk_i,             // system clock
   input  wire logic        rst_i,             // combined reset, active high
   input  wire logic [15:0] pwr_rec_i,         // record path enables
   input  wire logic [15:0] src_sel_i,         // serial port source selection
   output logic             shared_mic_dig_o,  // 1: shared pin is digital mic data
   output logic             dmic_clk_oe_o,     // digital mic clock output enable
   output logic             rec_out_oe_o,      // record data outputs enable
   output logic             port3_pd_o,        // port three pull-downs on
   output logic             port3_oe_o         // port three may drive
);
   // shared mic function and port three pull-downs follow the registers, other pin enables are fixed; reset forces documented pin states
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shared_mic_dig_o <= 1'b0;
         dmic_clk_oe_o    <= 1'b1;
         rec_out_oe_o     <= 1'b1;
         port3_pd_o       <= 1'b1;
         port3_oe_o       <= 1'b0;
      end else begin
         shared_mic_dig_o <= pwr_rec_i[rip_pkg::DMIC1L_BIT] | pwr_rec_i[rip_pkg::DMIC1R_BIT];
         dmic_clk_oe_o    <= 1'b1;
         rec_out_oe_o     <= 1'b1;
         port3_pd_o       <= ~src_sel_i[rip_pkg::AIF3_TRI_BIT] ? 1'b1 : 1'b0;
         port3_oe_o       <= 1'b0;
      end
   end

   a_mic_analog_rst : assert property (@(posedge clk_i) rst_i |=> !shared_mic_dig_o)
      else $error("shared mic pin not analogue after reset");
   a_rec_out_drv : assert property (@(posedge clk_i) rst_i |=> rec_out_oe_o && dmic_clk_oe_o)
      else $error("record or mic clock output not driven after reset");
endmodule : rip_pin_ctrl

// [tb/rip_host.sv]
// host model: classic wishbone master for the register bank
`timescale 1ns/1ns
module rip_host (
   input  wire logic        clk_i,  // system clock
   input  wire logic        ack_i,  // slave acknowledge
   input  wire logic        err_i,  // slave error answer
   output logic             cyc_o,  // bus cycle
   output logic             stb_o,  // strobe
   output logic             we_o,   // write enable
   output logic [11:0]      adr_o,  // byte address
   output logic [3:0]       sel_o,  // byte selects
   output logic [31:0]      dat_o   // write data
);
   // idle bus at time zero
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 12'h000;
      sel_o = 4'h0;
      dat_o = 32'h00000000;
   end

   // one cycle held until the slave answers; released data shows junk, not the last value
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      sel_o <= 4'hF;
      dat_o <= d;
      do @(posedge clk_i); while (!(ack_i === 1'b1 || err_i === 1'b1));
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      dat_o <= ~d;
   endtask : xfer
endmodule : rip_host

// [tb/rip_regs_tb.sv]
// self-checking bench for the reset, identification and power register bank
`timescale 1ns/1ns
module rip_regs_tb;
   typedef struct packed {logic rd; logic er; logic [15:0] v;} rip_note_type;
   localparam logic [15:0] ID = 16'h3C96;  // arbitrary identifier
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc, stb, we, ack, err, mic_dig, dclk_oe, rec_oe, p3_pd, p3_oe, srst;
   logic [11:0] adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   logic [15:0] p_out, p_in, p_line, p_rec, p_play, p_src;
   int          n_fail = 0;
   int          n_compared = 0;
   int          seed = 32'hef6b;
   rip_note_type notes[$];
   rip_note_type mon_n;
   logic [15:0] msk [1:6] = '{rip_pkg::MASK_PWR_OUT, rip_pkg::MASK_PWR_IN, rip_pkg::MASK_PWR_LINE,
                              rip_pkg::MASK_PWR_REC, rip_pkg::MASK_PWR_PLAY, rip_pkg::MASK_SRC_SEL};
   logic [15:0] dft [1:6] = '{rip_pkg::RST_PWR_OUT, rip_pkg::RST_PWR_IN, rip_pkg::RST_PWR_LINE,
                              rip_pkg::RST_PWR_REC, rip_pkg::RST_PWR_PLAY, rip_pkg::RST_SRC_SEL};
   logic [15:0] val [1:6];

   // 100 MHz clock
   always #5 clk_i = ~clk_i;

   rip_regs #(.PART_ID(ID), .CUST_CODE(8'hC4), .SI_REV(4'h7)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err), .pwr_out_o(p_out), .pwr_in_o(p_in),
      .pwr_line_o(p_line), .pwr_rec_o(p_rec), .pwr_play_o(p_play), .src_sel_o(p_src),
      .shared_mic_dig_o(mic_dig), .dmic_clk_oe_o(dclk_oe), .rec_out_oe_o(rec_oe),
      .port3_pd_o(p3_pd), .port3_oe_o(p3_oe), .soft_rst_o(srst));

   rip_host i_host (.clk_i(clk_i), .ack_i(ack), .err_i(err), .cyc_o(cyc), .stb_o(stb), .we_o(we),
                    .adr_o(adr), .sel_o(sel), .dat_o(wdat));

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // notes the expected answer, then runs the cycle
   task automatic acc(input logic w, input logic [9:0] idx, input logic [31:0] d,
                      input logic [15:0] ev, input logic er);
      notes.push_back('{rd: !w && !er, er: er, v: ev});
      i_host.xfer(w, {idx, 2'b00}, d);
   endtask : acc

   task automatic rdall(input logic def);
      for (int i = 1; i <= 6; i++) acc(1'b0, i[9:0], 32'h0, def ? dft[i] : val[i], 1'b0);
   endtask : rdall

   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report

   // monitor: each answer takes the oldest note
   always @(posedge clk_i) begin
      if (ack === 1'b1 || err === 1'b1) begin
         mon_n = notes.pop_front();
         check("err", {31'h0, err}, {31'h0, mon_n.er});
         if (mon_n.rd) check("rdat", rdat, {16'h0, mon_n.v});
      end
   end

   // main sequence
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      acc(1'b1, 10'h001, 32'h00003B37, 16'h0, 1'b0);
      repeat (12) @(posedge clk_i);
      acc(1'b0, 10'h001, 32'h0, 16'h0000, 1'b0);
      check("pins", {mic_dig, dclk_oe, rec_oe, p3_pd, p3_oe}, 5'b01110);
      rdall(1'b1);
      acc(1'b0, 10'h000, 32'h0, ID, 1'b0);
      acc(1'b0, 10'h100, 32'h0, 16'hC407, 1'b0);
      for (int i = 1; i <= 6; i++) begin
         val[i] = 16'($random(seed)) & msk[i];
         if (i == 4) val[i] = val[i] | 16'h0008;
         if (i == 6) val[i] = val[i] | 16'h0020;
         acc(1'b1, i[9:0], {16'h0, val[i]}, 16'h0, 1'b0);
      end
      rdall(1'b0);
      repeat (2) @(posedge clk_i);
      // register outputs must show what was written
      check("p_out", {16'h0, p_out}, {16'h0, val[1]});
      check("p_in", {16'h0, p_in}, {16'h0, val[2]});
      check("p_line", {16'h0, p_line}, {16'h0, val[3]});
      check("p_rec", {16'h0, p_rec}, {16'h0, val[4]});
      check("p_play", {16'h0, p_play}, {16'h0, val[5]});
      check("p_src", {16'h0, p_src}, {16'h0, val[6]});
      check("mic_dig", {31'h0, mic_dig}, 32'h1);
      check("p3_pd", {31'h0, p3_pd}, 32'h0);
      acc(1'b1, 10'h100, 32'h0000FFFF, 16'h0, 1'b0);
      acc(1'b0, 10'h100, 32'h0, 16'hC407, 1'b0);
      acc(1'b1, 10'h007, 32'h00001234, 16'h0, 1'b1);
      acc(1'b0, 10'h007, 32'h0, 16'h0, 1'b1);
      acc(1'b1, 10'h000, $random(seed), 16'h0, 1'b0);
      #1;
      check("srst", {31'h0, srst}, 32'h1);
      repeat (3) @(posedge clk_i);
      check("pins", {mic_dig, dclk_oe, rec_oe, p3_pd, p3_oe}, 5'b01110);
      check("p_in", {16'h0, p_in}, {16'h0, rip_pkg::RST_PWR_IN});
      rdall(1'b1);
      acc(1'b0, 10'h000, 32'h0, ID, 1'b0);
      // mid-run reset: a write to index zero in the power-on hold must not start a soft reset
      acc(1'b1, 10'h001, 32'h00003B37, 16'h0, 1'b0);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      acc(1'b1, 10'h000, 32'h0000FFFF, 16'h0, 1'b0);
      check("srst_por", {31'h0, srst}, 32'h0);
      repeat (12) @(posedge clk_i);
      rdall(1'b1);
      repeat (3) @(posedge clk_i);
      check("pending", notes.size(), 32'h0);
      final_report();
   end

   // watchdog against a hung handshake, far beyond the fewer than 200 cycles the tests need
   initial begin
      repeat (3000) @(posedge clk_i);
      n_fail++;
      final_report();
   end
endmodule : rip_regs_tb
